// ### sls_sequencer.sv
// Front-panel indicator sequencer: link, ready, run, error, supply and channel lamps.
// Assumes firmware status is on clk_sys; pin-level status is asynchronous.
// Notes on behaviour
// - Link lamp green while either network port has a connection, else dark.
// - Ready lamp steady green once the device is ready.
// - Ready lamp flashes yellow during a firmware update.
// - Ready lamp alternates green and yellow on supply voltage or temperature fault.
// - Ready lamp steady red for an invalid or reserved identification switch.
// - Ready lamp dark while the device is not ready.
// - Run lamp dark in the Init state.
// - Run lamp flashes at 2.5 Hz in Pre-Operational.
// - Run lamp single pulse, 200 ms lit then 1000 ms dark, in Safe-Operational.
// - Run lamp steady green in Operational.
// - Run lamp flashes at 10 Hz in Bootstrap.
// - Error lamp steady red on critical error, dark when no error.
// - Error lamp flashes at 2.5 Hz on a refused state change.
// - Error lamp double pulse when the process-data watchdog expired.
// - Sensor lamp green with power, dark without, red on overload.
// - Drive lamp green while actuator voltage is present.
// - Input channel lamp yellow while its input is set.
// - Output channel lamp yellow when set, red when faulted, dark otherwise.
// - Channel lamps indexed by byte then bit, sixteen in two bytes.
`default_nettype none

module sls_sequencer
  import sls_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int          NCH      = NUM_CHAN
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_b,
  input  wire logic           upstreamPortLink,
  input  wire logic           downstreamPortLink,
  input  wire logic           deviceReady,
  input  wire logic           firmwareUpdate,
  input  wire logic           switchInvalid,
  input  wire logic           sensorVoltFault,
  input  wire logic           tempCritical,
  input  wire logic [2:0]     runState,
  input  wire logic           criticalError,
  input  wire logic           configError,
  input  wire logic           watchdogExpired,
  input  wire logic           sensorPowerPresent,
  input  wire logic           sensorOverload,
  input  wire logic           drivePowerPresent,
  input  wire logic [NCH-1:0] chanIsOutput,
  input  wire logic [NCH-1:0] chanInputLevel,
  input  wire logic [NCH-1:0] chanOutputSet,
  input  wire logic [NCH-1:0] chanOutputFault,
  output logic                linkLedGreen,
  output logic                readyLedGreen,
  output logic                readyLedYellow,
  output logic                readyLedRed,
  output logic                runLedGreen,
  output logic                errorLedRed,
  output logic                sensorPowerLedGreen,
  output logic                sensorPowerLedRed,
  output logic                drivePowerLedGreen,
  output logic [NCH-1:0]      chanLedYellow,
  output logic [NCH-1:0]      chanLedRed
);

  localparam int PW = PIN_MISC + 2 * NCH;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [PW-1:0]  pinRaw;
  logic [PW-1:0]  sync1_reg;
  logic [PW-1:0]  sync2_reg;
  logic [PW-1:0]  sync3_reg;
  logic [PW-1:0]  pinFilt_reg;
  logic [PW-1:0]  pinFilt_next;
  logic           fUpLink;
  logic           fDownLink;
  logic           fSensFault;
  logic           fTempCrit;
  logic           fSensPresent;
  logic           fSensOverload;
  logic           fDrivePresent;
  logic [NCH-1:0] fChanIn;
  logic [NCH-1:0] fChanFault;
  logic           slowFlash;
  logic           fastFlash;
  logic           singlePulse;
  logic           doublePulse;
  logic           supplyWarn;
  logic           rdyGreen_next;
  logic           rdyYellow_next;
  logic           rdyRed_next;
  logic           run_next;
  logic           err_next;
  logic [NCH-1:0] chanYel_next;
  logic [NCH-1:0] chanRed_next;
  sls_run_t       runSt;

  // ==========================================================================
  // Pin synchroniser: three stages, a change is taken when stages two and three agree
  // ==========================================================================
  assign pinRaw = {chanOutputFault, chanInputLevel, drivePowerPresent, sensorOverload,
                   sensorPowerPresent, tempCritical, sensorVoltFault, downstreamPortLink,
                   upstreamPortLink};

  assign pinFilt_next = (sync2_reg ~^ sync3_reg) & sync3_reg |
                        (sync2_reg ^ sync3_reg) & pinFilt_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      sync3_reg   <= '0;
      pinFilt_reg <= '0;
    end else begin
      sync1_reg   <= pinRaw;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      pinFilt_reg <= pinFilt_next;
    end
  end

  assign fUpLink       = pinFilt_reg[0];
  assign fDownLink     = pinFilt_reg[1];
  assign fSensFault    = pinFilt_reg[2];
  assign fTempCrit     = pinFilt_reg[3];
  assign fSensPresent  = pinFilt_reg[4];
  assign fSensOverload = pinFilt_reg[5];
  assign fDrivePresent = pinFilt_reg[6];
  assign fChanIn       = pinFilt_reg[PIN_MISC +: NCH];
  assign fChanFault    = pinFilt_reg[PIN_MISC + NCH +: NCH];

  // ==========================================================================
  // Shared pattern timebase
  // ==========================================================================
  sls_timebase #(
    .TICK_CYC (TICK_CYC)
  ) u_timebase (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .slowFlash   (slowFlash),
    .fastFlash   (fastFlash),
    .singlePulse (singlePulse),
    .doublePulse (doublePulse)
  );

  // ==========================================================================
  // Ready lamp selection, highest priority first
  // ==========================================================================
  assign supplyWarn = fSensFault | fTempCrit;

  assign rdyRed_next    = switchInvalid;
  assign rdyYellow_next = !switchInvalid && (
                            (firmwareUpdate && slowFlash) ||
                            (!firmwareUpdate && supplyWarn && !slowFlash));
  assign rdyGreen_next  = !switchInvalid && !firmwareUpdate && (
                            (supplyWarn && slowFlash) ||
                            (!supplyWarn && deviceReady));

  // ==========================================================================
  // Run and error lamp selection
  // ==========================================================================
  assign runSt = sls_run_t'(runState);

  always_comb begin
    case (runSt)
      SLS_ST_INIT:   run_next = 1'b0;
      SLS_ST_PREOP:  run_next = slowFlash;
      SLS_ST_SAFEOP: run_next = singlePulse;
      SLS_ST_OP:     run_next = 1'b1;
      SLS_ST_BOOT:   run_next = fastFlash;
      default:       run_next = 1'b0;
    endcase
  end

  assign err_next = criticalError ? 1'b1 :
                    watchdogExpired ? doublePulse :
                    configError ? slowFlash : 1'b0;

  // ==========================================================================
  // Channel lamps: index is byte times eight plus bit
  // ==========================================================================
  for (genvar i = 0; i < NCH; i++) begin : g_chan
    assign chanYel_next[i] = chanIsOutput[i] ? (chanOutputSet[i] && !fChanFault[i])
                                             : fChanIn[i];
    assign chanRed_next[i] = chanIsOutput[i] && fChanFault[i];
  end

  // ==========================================================================
  // Lamp output registers
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      linkLedGreen        <= 1'b0;
      readyLedGreen       <= 1'b0;
      readyLedYellow      <= 1'b0;
      readyLedRed         <= 1'b0;
      runLedGreen         <= 1'b0;
      errorLedRed         <= 1'b0;
      sensorPowerLedGreen <= 1'b0;
      sensorPowerLedRed   <= 1'b0;
      drivePowerLedGreen  <= 1'b0;
    end else begin
      linkLedGreen        <= fUpLink | fDownLink;
      readyLedGreen       <= rdyGreen_next;
      readyLedYellow      <= rdyYellow_next;
      readyLedRed         <= rdyRed_next;
      runLedGreen         <= run_next;
      errorLedRed         <= err_next;
      sensorPowerLedGreen <= fSensPresent && !fSensOverload;
      sensorPowerLedRed   <= fSensOverload;
      drivePowerLedGreen  <= fDrivePresent;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chanLedYellow <= '0;
      chanLedRed    <= '0;
    end else begin
      chanLedYellow <= chanYel_next;
      chanLedRed    <= chanRed_next;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_bothLinksDown;
    !fUpLink && !fDownLink;
  endsequence

  sequence s_linkDark;
    !linkLedGreen;
  endsequence

  AST_LINK_ON: assert property ((fUpLink || fDownLink) |=> linkLedGreen)
    else $error("Link lamp dark with a port connected.");

  AST_LINK_OFF: assert property (s_bothLinksDown |=> s_linkDark)
    else $error("Link lamp lit with no port connected.");

  AST_RDY_RED: assert property (
    switchInvalid |=> readyLedRed && !readyLedGreen && !readyLedYellow)
    else $error("Invalid switch did not give a plain red ready lamp.");

  AST_RDY_GREEN: assert property (
    deviceReady && !switchInvalid && !firmwareUpdate && !supplyWarn
      |=> readyLedGreen && !readyLedYellow && !readyLedRed)
    else $error("Ready device did not show steady green.");

  AST_RDY_DARK: assert property (
    !deviceReady && !switchInvalid && !firmwareUpdate && !supplyWarn
      |=> !readyLedGreen && !readyLedYellow && !readyLedRed)
    else $error("Ready lamp lit for a device that is not ready.");

  AST_RDY_FW: assert property (
    firmwareUpdate && !switchInvalid |=> !readyLedGreen && readyLedYellow == $past(slowFlash))
    else $error("Firmware update did not flash the ready lamp yellow.");

  AST_RDY_WARN: assert property (
    supplyWarn && !firmwareUpdate && !switchInvalid
      |=> (readyLedGreen != readyLedYellow) && readyLedGreen == $past(slowFlash))
    else $error("Supply warning did not alternate green and yellow.");

  AST_RUN_INIT: assert property (runSt == SLS_ST_INIT |=> !runLedGreen)
    else $error("Run lamp lit in the Init state.");

  AST_RUN_OP: assert property (
    (runSt == SLS_ST_OP) [*2] |=> runLedGreen && $past(runLedGreen))
    else $error("Run lamp not steady in the Operational state.");

  AST_RUN_PREOP: assert property (
    runSt == SLS_ST_PREOP |=> runLedGreen == $past(slowFlash))
    else $error("Run lamp not on the slow flash in Pre-Operational.");

  AST_RUN_SAFEOP: assert property (
    runSt == SLS_ST_SAFEOP |=> runLedGreen == $past(singlePulse))
    else $error("Run lamp not on the single pulse in Safe-Operational.");

  AST_RUN_BOOT: assert property (
    runSt == SLS_ST_BOOT |=> runLedGreen == $past(fastFlash))
    else $error("Run lamp not on the fast flash in Bootstrap.");

  AST_ERR_CRIT: assert property (criticalError |=> errorLedRed)
    else $error("Critical error did not light the error lamp.");

  AST_ERR_NONE: assert property (
    !criticalError && !watchdogExpired && !configError |=> !errorLedRed)
    else $error("Error lamp lit with no error.");

  AST_ERR_WDOG: assert property (
    !criticalError && watchdogExpired |=> errorLedRed == $past(doublePulse))
    else $error("Watchdog expiry did not give the double pulse.");

  AST_ERR_CFG: assert property (
    !criticalError && !watchdogExpired && configError |=> errorLedRed == $past(slowFlash))
    else $error("Configuration error did not give the slow flash.");

  AST_SENS: assert property (
    fSensOverload |=> sensorPowerLedRed && !sensorPowerLedGreen)
    else $error("Sensor overload did not show red alone.");

  AST_DRIVE: assert property (fDrivePresent |=> drivePowerLedGreen)
    else $error("Drive power lamp dark with voltage present.");

  AST_CHAN_IN: assert property (
    !chanIsOutput[0] |=> chanLedYellow[0] == $past(fChanIn[0]) && !chanLedRed[0])
    else $error("Input channel lamp does not follow its input.");

  AST_CHAN_FAULT: assert property (
    chanIsOutput[NCH-1] && fChanFault[NCH-1]
      |=> chanLedRed[NCH-1] && !chanLedYellow[NCH-1])
    else $error("Faulted output channel lamp not red.");

endmodule : sls_sequencer

`default_nettype wire

// ### sls_pkg.sv
// Constants shared by the status indicator sequencer and its timebase.
// Assumes a single 100 MHz system clock.
`default_nettype none

package sls_pkg;

  // ==========================================================================
  // Clock and timebase
  // ==========================================================================
  localparam int CLK_MHZ      = 100;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;

  // ==========================================================================
  // Pattern timing, in milliseconds unless named otherwise
  // ==========================================================================
  localparam int SLOW_FLASH_DHZ = 25;
  localparam int FAST_FLASH_DHZ = 100;
  localparam int PULSE_ON_MS    = 200;
  localparam int PULSE_OFF_MS   = 1000;
  localparam int DBL_GAP_MS     = 200;

  localparam int PHASE_W = 11;
  localparam logic [PHASE_W-1:0] SLOW_PERIOD = PHASE_W'(10000 / SLOW_FLASH_DHZ);
  localparam logic [PHASE_W-1:0] FAST_PERIOD = PHASE_W'(10000 / FAST_FLASH_DHZ);
  localparam logic [PHASE_W-1:0] SLOW_HALF   = PHASE_W'(5000 / SLOW_FLASH_DHZ);
  localparam logic [PHASE_W-1:0] FAST_HALF   = PHASE_W'(5000 / FAST_FLASH_DHZ);
  localparam logic [PHASE_W-1:0] SGL_ON      = PHASE_W'(PULSE_ON_MS);
  localparam logic [PHASE_W-1:0] SGL_PERIOD  = PHASE_W'(PULSE_ON_MS + PULSE_OFF_MS);
  localparam logic [PHASE_W-1:0] DBL_ON2     = PHASE_W'(PULSE_ON_MS + DBL_GAP_MS);
  localparam logic [PHASE_W-1:0] DBL_OFF2    = PHASE_W'(2 * PULSE_ON_MS + DBL_GAP_MS);
  localparam logic [PHASE_W-1:0] DBL_PERIOD  =
      PHASE_W'(2 * PULSE_ON_MS + DBL_GAP_MS + PULSE_OFF_MS);
  localparam logic [PHASE_W-1:0] PHASE_ONE   = 11'h001;

  // ==========================================================================
  // Communication state encoding and pin synchroniser layout
  // ==========================================================================
  typedef enum logic [2:0] {
    SLS_ST_INIT   = 3'h0,
    SLS_ST_PREOP  = 3'h1,
    SLS_ST_SAFEOP = 3'h2,
    SLS_ST_OP     = 3'h3,
    SLS_ST_BOOT   = 3'h4
  } sls_run_t;

  localparam int NUM_CHAN  = 16;
  localparam int CHAN_BITS = 8;
  localparam int PIN_MISC  = 7;
  localparam int PIN_W     = PIN_MISC + 2 * NUM_CHAN;

endpackage : sls_pkg

`default_nettype wire

// ### sls_timebase.sv
// Shared millisecond timebase and the flash and pulse pattern generator.
// Assumes clk_sys at the package rate; all patterns start together at reset.
`default_nettype none

module sls_timebase
  import sls_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  output logic      slowFlash,
  output logic      fastFlash,
  output logic      singlePulse,
  output logic      doublePulse
);

  localparam int PRE_W = $clog2(TICK_CYC + 1);

  logic [PRE_W-1:0]   preCnt_reg;
  logic [PHASE_W-1:0] slowPh_reg;
  logic [PHASE_W-1:0] fastPh_reg;
  logic [PHASE_W-1:0] sglPh_reg;
  logic [PHASE_W-1:0] dblPh_reg;
  logic               msTick;
  logic               dblOn;

  // ==========================================================================
  // Millisecond tick and phase counters
  // ==========================================================================
  assign msTick = (preCnt_reg == PRE_W'(TICK_CYC - 1));
  assign dblOn  = (dblPh_reg < SGL_ON) || ((dblPh_reg >= DBL_ON2) && (dblPh_reg < DBL_OFF2));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      preCnt_reg <= '0;
    end else begin
      preCnt_reg <= msTick ? '0 : preCnt_reg + PRE_W'(1);
    end
  end

  // All counters share one tick and one reset, so equal patterns stay in phase.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slowPh_reg <= '0;
      fastPh_reg <= '0;
      sglPh_reg  <= '0;
      dblPh_reg  <= '0;
    end else if (msTick) begin
      slowPh_reg <= (slowPh_reg == SLOW_PERIOD - PHASE_ONE) ? '0 : slowPh_reg + PHASE_ONE;
      fastPh_reg <= (fastPh_reg == FAST_PERIOD - PHASE_ONE) ? '0 : fastPh_reg + PHASE_ONE;
      sglPh_reg  <= (sglPh_reg == SGL_PERIOD - PHASE_ONE) ? '0 : sglPh_reg + PHASE_ONE;
      dblPh_reg  <= (dblPh_reg == DBL_PERIOD - PHASE_ONE) ? '0 : dblPh_reg + PHASE_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slowFlash   <= 1'b0;
      fastFlash   <= 1'b0;
      singlePulse <= 1'b0;
      doublePulse <= 1'b0;
    end else begin
      slowFlash   <= (slowPh_reg < SLOW_HALF);
      fastFlash   <= (fastPh_reg < FAST_HALF);
      singlePulse <= (sglPh_reg < SGL_ON);
      doublePulse <= dblOn;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_DBL_WRAP: assert property (
    msTick && (dblPh_reg == DBL_PERIOD - PHASE_ONE) |=> (dblPh_reg == '0) ##1 doublePulse)
    else $error("Double pulse phase did not restart lit.");

  AST_SGL_GAP: assert property (
    msTick && (sglPh_reg == SGL_ON - PHASE_ONE) |=> ##1 !singlePulse)
    else $error("Single pulse stayed lit past its on time.");

endmodule : sls_timebase

`default_nettype wire

// ### sls_lamp_watch.sv
// Partner model: an operator's eye on one lamp, counting lit cycles and turn-ons.
// Assumes the lamp is a registered level on clk_sys; clear restarts both counts.
`default_nettype none

module sls_lamp_watch (
  input  wire logic  clk_sys,
  input  wire logic  clear,
  input  wire logic  lamp,
  output logic [15:0] litCount,
  output logic [3:0]  riseCount
);
  timeunit 1ns;
  timeprecision 1ps;

  logic prevLamp_reg = 1'b0;

  // ==========================================================================
  // Counting
  // ==========================================================================
  always @(posedge clk_sys) begin
    prevLamp_reg <= lamp;
    if (clear) begin
      litCount  <= 16'h0000;
      riseCount <= 4'h0;
    end else begin
      litCount  <= litCount + 16'(lamp);
      riseCount <= riseCount + 4'(lamp & ~prevLamp_reg);
    end
  end
endmodule : sls_lamp_watch

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the indicator sequencer.
// Assumes a 1 ms tick of 10 cycles so that every pattern fits a short run.
`default_nettype none

module tb_top;
  import sls_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic upL = 1'b0, dnL = 1'b0, devRdy = 1'b0, fwUpd = 1'b0, swInv = 1'b0;
  logic voltF = 1'b0, tempC = 1'b0, critE = 1'b0, cfgE = 1'b0, wdE = 1'b0;
  logic senP = 1'b0, senO = 1'b0, drvP = 1'b0, clr = 1'b0;
  logic [2:0]  runState = 3'h0;
  logic [15:0] isOut = 16'h0000, inL = 16'h0000, oSet = 16'h0000, flt = 16'h0000;
  logic linkG, rdyG, rdyY, rdyR, runG, errR, senG, senR, drvG;
  logic [15:0] chY, chR;
  logic [3:0][15:0] lit;
  logic [3:0][3:0]  rise;
  logic [3:0]  watched;
  int err_total = 0;
  int compares = 0;
  int ph = 0;

  always #5 clk_sys = ~clk_sys;

  sls_sequencer #(.TICK_CYC(10)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .upstreamPortLink(upL), .downstreamPortLink(dnL),
    .deviceReady(devRdy), .firmwareUpdate(fwUpd), .switchInvalid(swInv),
    .sensorVoltFault(voltF), .tempCritical(tempC), .runState(runState),
    .criticalError(critE), .configError(cfgE), .watchdogExpired(wdE),
    .sensorPowerPresent(senP), .sensorOverload(senO), .drivePowerPresent(drvP),
    .chanIsOutput(isOut), .chanInputLevel(inL), .chanOutputSet(oSet),
    .chanOutputFault(flt), .linkLedGreen(linkG), .readyLedGreen(rdyG),
    .readyLedYellow(rdyY), .readyLedRed(rdyR), .runLedGreen(runG), .errorLedRed(errR),
    .sensorPowerLedGreen(senG), .sensorPowerLedRed(senR), .drivePowerLedGreen(drvG),
    .chanLedYellow(chY), .chanLedRed(chR));

  assign watched = {rdyY, rdyG, errR, runG};
  for (genvar i = 0; i < 4; i++) begin : g_watch
    sls_lamp_watch u_watch (.clk_sys(clk_sys), .clear(clr), .lamp(watched[i]),
                            .litCount(lit[i]), .riseCount(rise[i]));
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk_bit(string nm, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(string nm, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_vec

  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic watch(int n);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(n);
  endtask : watch

  task automatic run_pat(logic [2:0] st, int n, logic [15:0] litE, logic [3:0] riseE);
    runState = st;
    cyc(2);
    watch(n);
    chk_vec("run lit", litE, lit[0]);
    chk_vec("run rises", 16'(riseE), 16'(rise[0]));
  endtask : run_pat

  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    #800000;
    err_total++;
    complete_run();
  end

  initial begin
    cyc(8);
    rst_b = 1'b1;
    cyc(2);
    chk_bit("link", 1'b0, linkG);
    chk_bit("ready green", 1'b0, rdyG);
    for (int i = 1; i < 4; i++) begin
      upL = i[0];
      dnL = i[1];
      cyc(5);
      chk_bit("link", 1'b1, linkG);
    end
    upL = 1'b0;
    dnL = 1'b0;
    cyc(5);
    chk_bit("link", 1'b0, linkG);
    devRdy = 1'b1;
    cyc(2);
    chk_bit("ready green", 1'b1, rdyG);
    swInv = 1'b1;
    fwUpd = 1'b1;
    cyc(2);
    chk_bit("ready red", 1'b1, rdyR);
    chk_bit("ready green", 1'b0, rdyG);
    chk_bit("ready yellow", 1'b0, rdyY);
    swInv = 1'b0;
    cyc(2);
    watch(4000);
    chk_vec("ready yellow lit", 16'd2000, lit[3]);
    chk_vec("ready green lit", 16'd0, lit[2]);
    fwUpd = 1'b0;
    for (int k = 0; k < 2; k++) begin
      voltF = (k == 0);
      tempC = (k == 1);
      cyc(5);
      watch(4000);
      chk_vec("warn green lit", 16'd2000, lit[2]);
      chk_vec("warn yellow lit", 16'd2000, lit[3]);
      chk_vec("warn green rises", 16'd1, 16'(rise[2]));
    end
    tempC = 1'b0;
    devRdy = 1'b0;
    cyc(5);
    chk_vec("ready lamps", 16'h0000, 16'({rdyG, rdyY, rdyR}));
    for (int i = 0; i < 8; i++) begin
      if (i inside {0, 3, 5, 6, 7}) begin
        runState = 3'(i);
        cyc(2);
        chk_bit("run steady", 1'(i == 3), runG);
      end
    end
    run_pat(SLS_ST_PREOP, 4000, 16'd2000, 4'h1);
    run_pat(SLS_ST_BOOT, 1000, 16'd500, 4'h1);
    run_pat(SLS_ST_SAFEOP, 12000, 16'd2000, 4'h1);
    critE = 1'b1;
    wdE = 1'b1;
    cyc(2);
    chk_bit("error", 1'b1, errR);
    critE = 1'b0;
    cyc(2);
    watch(16000);
    chk_vec("error lit", 16'd4000, lit[1]);
    chk_vec("error rises", 16'd2, 16'(rise[1]));
    wdE = 1'b0;
    cyc(2);
    chk_bit("error", 1'b0, errR);
    runState = SLS_ST_PREOP;
    cfgE = 1'b1;
    cyc(2);
    watch(4000);
    chk_vec("cfg error lit", 16'd2000, lit[1]);
    for (int i = 0; i < 4000; i++) begin
      cyc(1);
      if (runG !== errR) ph++;
    end
    chk_vec("phase diff", 16'd0, 16'(ph));
    cfgE = 1'b0;
    senP = 1'b1;
    drvP = 1'b1;
    cyc(5);
    chk_vec("sensor lamp", 16'h0002, 16'({senG, senR}));
    chk_bit("drive lamp", 1'b1, drvG);
    senO = 1'b1;
    drvP = 1'b0;
    cyc(5);
    chk_vec("sensor lamp", 16'h0001, 16'({senG, senR}));
    chk_bit("drive lamp", 1'b0, drvG);
    senO = 1'b0;
    senP = 1'b0;
    cyc(5);
    chk_vec("sensor lamp", 16'h0000, 16'({senG, senR}));
    for (int k = 0; k < 2; k++) begin
      isOut = k ? 16'h00ff : 16'hff00;
      inL = 16'h5aa5;
      oSet = 16'h3cc3;
      flt = 16'h8ff1;
      cyc(5);
      chk_vec("chan yellow", (~isOut & inL) | (isOut & oSet & ~flt), chY);
      chk_vec("chan red", isOut & flt, chR);
    end
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
